// ==== rtl/transceiver_power_mode_sequencer.sv ====
// How it works
// - Ready output goes high when start-up ends; host may then talk SPI.
// - Converter build: RC soft start, xtal after supply ok, full regulation after xtal.
// - Plain build: RC clocks supply check, xtal, ready after xtal, RC stopped.
// - After reset the device settles in standby; only xtal (and converter) run.
// - Sleep and protect are entered only from standby; transmit and receive also by turnaround.
// - Modes follow host commands; return after transmit is automatic.
// - Protect command switches off everything except a resistive load.
// - Protect mode is never left except by a fresh power-on.
// - Deep-sleep bit set: converter build sleeps, plain build powers down.
// - Converter sleep stops xtal; converter runs on slow RC, on/off loop.
// - Receive/transmit turnaround, with or without hop, within 128 us.
// - Standby to active radio with synthesizer settled within 150 us.
// - Power-down back to standby within 1.5 ms, xtal dominated.
// - Deep-sleep back to regulated converter within 4.5 ms.
// - Transmit command taken in standby only; after packet go receive when auto-ack set.
// - Power-down stops all clocks; register contents are kept.
`timescale 1ns/1ns
module transceiver_power_mode_sequencer
    import pwr_seq_pkg::*;
(
    // Clock and reset (reset is battery insertion)
    input  wire logic     clk_sys_i,
    input  wire logic     reset_n_i,
    // Build option: high for the boost-converter version
    input  wire logic     boost_version_i,
    // Analogue status, asynchronous
    input  wire status_s  status_i,
    // Host command, decoded from SPI on this clock
    input  wire logic     cmd_valid_i,
    input  wire cmd_e     cmd_i,
    input  wire logic     deep_sleep_enable_bit_i,
    input  wire logic     auto_ack_i,
    // Outputs
    output enables_s      enables_o,
    output logic          ready_irq_o,
    output mode_e         mode_o,
    output logic          battery_protect_mode_o,
    output logic          timeout_o
);

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    status_s status_s_w;

    pwr_seq_sync #(
        .WIDTH (STATUS_W)
    ) u_sync (
        .clk_sys_i (clk_sys_i),
        .reset_n_i (reset_n_i),
        .async_i   (status_i),
        .sync_o    (status_s_w)
    );

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        mode_e              mode;
        logic               boost_ver;
        logic               ver_caught;
        logic               ready;
        logic               timeout;
        logic [CNT_W-1:0]   cnt;
        logic [CNT_W-1:0]   dwell;
        enables_s           en;
    } seq_state_s;

    seq_state_s state_q;
    seq_state_s state_d;

    logic cmd_take;
    assign cmd_take = cmd_valid_i && state_q.ready;

    always_comb begin
        state_d         = state_q;
        state_d.timeout = 1'b0;
        // Strap is caught once after release, never under reset
        if (!state_q.ver_caught) begin
            state_d.boost_ver  = boost_version_i;
            state_d.ver_caught = 1'b1;
        end
        if (state_q.cnt != '0) begin
            state_d.cnt = state_q.cnt - 1'b1;
        end

        case (state_q.mode)
            ST_RC_START: begin
                state_d.en.rc_osc_en        = 1'b1;
                state_d.en.rf_core_en       = 1'b0;
                // Strap value of this cycle, so soft start never blinks off
                state_d.en.boost_soft_start = state_d.boost_ver;
                if (state_q.ver_caught && status_s_w.supply_ok) begin
                    state_d.en.xtal_en = 1'b1;
                    state_d.mode       = ST_XTAL_WAIT;
                end
            end
            ST_XTAL_WAIT: begin
                if (status_s_w.xtal_ok) begin
                    state_d.en.boost_full_reg   = state_q.boost_ver;
                    state_d.en.boost_soft_start = 1'b0;
                    state_d.en.rc_osc_en        = 1'b0;
                    state_d.ready               = 1'b1;
                    state_d.mode                = ST_STANDBY;
                end
            end
            ST_STANDBY: begin
                state_d.en.rf_core_en = 1'b0;
                state_d.en.tx_en      = 1'b0;
                state_d.en.rx_en      = 1'b0;
                if (cmd_take && cmd_i == CMD_BATT_PROT) begin
                    state_d.en   = '{resistive_load_only: 1'b1, default: 1'b0};
                    state_d.mode = ST_BATT_PROT;
                end else if (cmd_take && deep_sleep_enable_bit_i) begin
                    // deep sleep or power-down by build
                    state_d.en.xtal_en = 1'b0;
                    if (state_q.boost_ver) begin
                        state_d.en.lf_rc_osc_en    = 1'b1;
                        state_d.en.boost_full_reg  = 1'b0;
                        state_d.en.boost_bang_bang = 1'b1;
                    end else begin
                        state_d.en.clocks_en = 1'b0;
                    end
                    state_d.mode = ST_SLEEP;
                end else if (cmd_take && (cmd_i == CMD_TX || cmd_i == CMD_RX)) begin
                    state_d.en.rf_core_en = 1'b1;
                    state_d.cnt  = CNT_W'(STDBY_ACTIVE_CYC - 1);
                    state_d.en.tx_en = (cmd_i == CMD_TX);
                    state_d.en.rx_en = (cmd_i == CMD_RX);
                    state_d.mode = ST_SETTLE;
                end
            end
            ST_SETTLE, ST_TURN: begin
                if (status_s_w.pll_locked || state_q.cnt == '0) begin
                    state_d.timeout = !status_s_w.pll_locked;
                    state_d.mode    = state_q.en.tx_en ? ST_TX : ST_RX;
                end
            end
            ST_TX: begin
                if (status_s_w.packet_done) begin
                    if (auto_ack_i) begin
                        state_d.en.tx_en = 1'b0;
                        state_d.en.rx_en = 1'b1;
                        state_d.cnt  = CNT_W'(TRX_TURN_CYC - 1);
                        state_d.mode = ST_TURN;
                    end else begin
                        state_d.mode = ST_STANDBY;
                    end
                end else if (cmd_take && cmd_i == CMD_STANDBY) begin
                    state_d.mode = ST_STANDBY;
                end else if (cmd_take && cmd_i == CMD_TURN) begin
                    state_d.en.tx_en = 1'b0;
                    state_d.en.rx_en = 1'b1;
                    state_d.cnt      = CNT_W'(TRX_TURN_CYC - 1);
                    state_d.mode     = ST_TURN;
                end
            end
            ST_RX: begin
                if (cmd_take && cmd_i == CMD_STANDBY) begin
                    state_d.mode = ST_STANDBY;
                end else if (cmd_take && cmd_i == CMD_TURN) begin
                    state_d.en.tx_en = 1'b1;
                    state_d.en.rx_en = 1'b0;
                    state_d.cnt      = CNT_W'(TRX_TURN_CYC - 1);
                    state_d.mode     = ST_TURN;
                end
            end
            ST_SLEEP: begin
                // Wake when the deep-sleep bit is cleared
                if (cmd_take && !deep_sleep_enable_bit_i) begin
                    state_d.en.clocks_en = 1'b1;
                    state_d.en.xtal_en   = 1'b1;
                    state_d.cnt  = state_q.boost_ver ? CNT_W'(DEEP_WAKE_CYC - 1)
                                                     : CNT_W'(PD_STDBY_CYC - 1);
                    state_d.mode = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if ((status_s_w.xtal_ok
                     && (!state_q.boost_ver || status_s_w.boost_settled))
                    || state_q.cnt == '0) begin
                    state_d.timeout            = !(status_s_w.xtal_ok
                        && (!state_q.boost_ver || status_s_w.boost_settled));
                    state_d.en.lf_rc_osc_en    = 1'b0;
                    state_d.en.boost_bang_bang = 1'b0;
                    state_d.en.boost_full_reg  = state_q.boost_ver;
                    state_d.mode               = ST_STANDBY;
                end
            end
            ST_BATT_PROT: begin
                state_d.en    = '{resistive_load_only: 1'b1, default: 1'b0};
                state_d.ready = 1'b0;
            end
            default: begin
                state_d.mode = ST_BATT_PROT;
            end
        endcase
        // Cycles spent in one mode, for the transition-time checks
        if (state_d.mode != state_q.mode) begin
            state_d.dwell = '0;
        end else if (state_q.dwell != '1) begin
            state_d.dwell = state_q.dwell + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= '{mode: ST_RC_START, en: ENABLES_RST, default: '0};
        end else begin
            state_q <= state_d;
        end
    end

    assign enables_o              = state_q.en;
    assign ready_irq_o            = state_q.ready;
    assign mode_o                 = state_q.mode;
    assign battery_protect_mode_o = (state_q.mode == ST_BATT_PROT);
    assign timeout_o              = state_q.timeout;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_ready_after_xtal;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (state_q.mode == ST_XTAL_WAIT && status_s_w.xtal_ok) |=> ready_irq_o;
    endproperty
    a_ready_after_xtal: assert property (p_ready_after_xtal)
        else $error("ready not raised after crystal");

    property p_rc_stop;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        $rose(ready_irq_o) |-> !enables_o.rc_osc_en && enables_o.xtal_en;
    endproperty
    a_rc_stop: assert property (p_rc_stop)
        else $error("RC still running at ready");

    property p_rf_off_start;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (mode_o == ST_RC_START || mode_o == ST_XTAL_WAIT) |-> !enables_o.rf_core_en;
    endproperty
    a_rf_off_start: assert property (p_rf_off_start)
        else $error("RF core on during start-up");

    property p_full_reg;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        $rose(ready_irq_o) |-> enables_o.boost_full_reg == state_q.boost_ver;
    endproperty
    a_full_reg: assert property (p_full_reg)
        else $error("converter regulation wrong at ready");

    property p_from_standby;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        ($changed(mode_o) && (mode_o == ST_SETTLE || mode_o == ST_SLEEP
                               || mode_o == ST_BATT_PROT))
        |-> $past(mode_o) == ST_STANDBY;
    endproperty
    a_from_standby: assert property (p_from_standby)
        else $error("mode entered not from standby");

    property p_prot_sticky;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        battery_protect_mode_o |=> battery_protect_mode_o
                                   && enables_o.resistive_load_only && !enables_o.xtal_en;
    endproperty
    a_prot_sticky: assert property (p_prot_sticky)
        else $error("protect mode left");

    property p_sleep_xtal_off;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (mode_o == ST_SLEEP) |-> !enables_o.xtal_en
            && (state_q.boost_ver ? enables_o.boost_bang_bang : !enables_o.clocks_en);
    endproperty
    a_sleep_xtal_off: assert property (p_sleep_xtal_off)
        else $error("sleep enables wrong");

    property p_settle_bound;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (mode_o == ST_SETTLE) |-> (state_q.dwell < CNT_W'(STDBY_ACTIVE_CYC));
    endproperty
    a_settle_bound: assert property (p_settle_bound)
        else $error("standby to active too slow");

    property p_turn_bound;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (mode_o == ST_TURN) |-> (state_q.dwell < CNT_W'(TRX_TURN_CYC));
    endproperty
    a_turn_bound: assert property (p_turn_bound)
        else $error("turnaround too slow");

    property p_ack_rx;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (mode_o == ST_TX && status_s_w.packet_done && auto_ack_i)
        |=> enables_o.rx_en && !enables_o.tx_en;
    endproperty
    a_ack_rx: assert property (p_ack_rx)
        else $error("no receive after packet with ack");

endmodule : transceiver_power_mode_sequencer

// ==== rtl/pwr_seq_pkg.sv ====
package pwr_seq_pkg;

    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ            = 50_000_000;
    localparam int unsigned CLK_NS            = 20;
    // Longest times and one typical time, in their own units
    localparam int unsigned TRX_TURN_US       = 128;
    localparam int unsigned STDBY_ACTIVE_US   = 150;
    localparam int unsigned PD_STDBY_TYP_US   = 800;
    localparam int unsigned PD_STDBY_MAX_US   = 1500;
    localparam int unsigned DEEP_WAKE_MAX_US  = 4500;
    // Cycle counts, rounded down for longest times
    localparam int unsigned TRX_TURN_CYC      = (TRX_TURN_US * 1000) / CLK_NS;
    localparam int unsigned STDBY_ACTIVE_CYC  = (STDBY_ACTIVE_US * 1000) / CLK_NS;
    localparam int unsigned PD_STDBY_CYC      = (PD_STDBY_MAX_US * 1000) / CLK_NS;
    localparam int unsigned DEEP_WAKE_CYC     = (DEEP_WAKE_MAX_US * 1000) / CLK_NS;
    localparam int unsigned CNT_W             = 18;

    // ----------------------------------------------------------------
    // Modes and commands
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_RC_START   = 4'h0,
        ST_XTAL_WAIT  = 4'h1,
        ST_STANDBY    = 4'h2,
        ST_SETTLE     = 4'h3,
        ST_TX         = 4'h4,
        ST_RX         = 4'h5,
        ST_TURN       = 4'h6,
        ST_SLEEP      = 4'h7,
        ST_WAKE       = 4'h8,
        ST_BATT_PROT  = 4'h9
    } mode_e;

    typedef enum logic [2:0] {
        CMD_NONE      = 3'h0,
        CMD_TX        = 3'h1,
        CMD_RX        = 3'h2,
        CMD_STANDBY   = 3'h3,
        CMD_BATT_PROT = 3'h4,
        CMD_TURN      = 3'h5
    } cmd_e;

    // Analogue block enables, one bundle
    typedef struct packed {
        logic rc_osc_en;
        logic lf_rc_osc_en;
        logic xtal_en;
        logic boost_soft_start;
        logic boost_full_reg;
        logic boost_bang_bang;
        logic rf_core_en;
        logic tx_en;
        logic rx_en;
        logic clocks_en;
        logic resistive_load_only;
    } enables_s;

    localparam enables_s ENABLES_RST = '{rc_osc_en: 1'b1, boost_soft_start: 1'b1,
                                         clocks_en: 1'b1, default: 1'b0};

    // Analogue status inputs, one bundle
    typedef struct packed {
        logic supply_ok;
        logic xtal_ok;
        logic boost_settled;
        logic pll_locked;
        logic packet_done;
    } status_s;

    localparam int unsigned STATUS_W = $bits(status_s);

endpackage : pwr_seq_pkg

// ==== rtl/pwr_seq_sync.sv ====
`timescale 1ns/1ns
module pwr_seq_sync
    import pwr_seq_pkg::*;
#(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk_sys_i,
    input  wire logic             reset_n_i,
    // Data
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } sync_state_s;

    sync_state_s state_q;
    sync_state_s state_d;

    always_comb begin
        state_d      = state_q;
        state_d.meta = async_i;
        state_d.sync = state_q.meta;
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign sync_o = state_q.sync;

endmodule : pwr_seq_sync

// ==== tb/host_model.sv ====
`timescale 1ns/1ns
module host_model
    import pwr_seq_pkg::*;
(
    // Clock and reset
    input  wire logic clk_sys_i,
    input  wire logic reset_n_i,
    // Device side
    input  wire logic ready_irq_i,
    output logic      cmd_valid_o,
    output cmd_e      cmd_o,
    output logic      deep_o,
    // Bench side
    input  wire logic batt_low_i,
    input  wire logic bypass_ready_i,
    input  wire logic req_i,
    input  wire cmd_e req_cmd_i,
    input  wire logic req_deep_i,
    output logic      done_o
);
    logic ready_q;

    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cmd_valid_o <= 1'b0;
            cmd_o       <= CMD_NONE;
            deep_o      <= 1'b0;
            done_o      <= 1'b0;
            ready_q     <= 1'b0;
        end else begin
            ready_q     <= ready_irq_i;
            cmd_valid_o <= 1'b0;
            done_o      <= 1'b0;
            if (ready_irq_i && !ready_q && batt_low_i) begin
                cmd_valid_o <= 1'b1;
                cmd_o       <= CMD_BATT_PROT;
            end else if (req_i && !done_o && (ready_irq_i || bypass_ready_i)) begin
                cmd_valid_o <= 1'b1;
                cmd_o       <= req_cmd_i;
                deep_o      <= req_deep_i;
                done_o      <= 1'b1;
            end
        end
    end
endmodule : host_model

// ==== tb/transceiver_power_mode_sequencer_tb.sv ====
`timescale 1ns/1ns
module transceiver_power_mode_sequencer_tb
    import pwr_seq_pkg::*;
;
    localparam enables_s PROT_EN = '{resistive_load_only: 1'b1, default: 1'b0};
    logic     clk_sys_i, reset_n_i, boost, cmd_valid, deep, auto_ack, ready, prot, tmo;
    logic     batt_low, bypass, req, req_deep, done, saw_to;
    status_s  st;
    cmd_e     cmd, req_cmd;
    enables_s en;
    mode_e    mode;
    int       errors, cmp_count;

    always #10 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) if (tmo === 1'b1) saw_to <= 1'b1;

    transceiver_power_mode_sequencer u_dut (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .boost_version_i(boost),
        .status_i(st), .cmd_valid_i(cmd_valid), .cmd_i(cmd),
        .deep_sleep_enable_bit_i(deep), .auto_ack_i(auto_ack), .enables_o(en),
        .ready_irq_o(ready), .mode_o(mode), .battery_protect_mode_o(prot), .timeout_o(tmo));

    host_model u_host (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .ready_irq_i(ready),
        .cmd_valid_o(cmd_valid), .cmd_o(cmd), .deep_o(deep), .batt_low_i(batt_low),
        .bypass_ready_i(bypass), .req_i(req), .req_cmd_i(req_cmd),
        .req_deep_i(req_deep), .done_o(done));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic complete_run;
        if (errors == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : complete_run

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Inputs move 2 ns after the edge, outputs read there too
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #2;
    endtask : tick

    task automatic wait_mode(input mode_e exp, input int limit);
        for (int i = 0; i < limit && mode !== exp; i++) tick(1);
        check("mode", mode, exp);
    endtask : wait_mode

    task automatic send(input cmd_e c, input logic d);
        req      = 1'b1;
        req_cmd  = c;
        req_deep = d;
        for (int i = 0; i < 50 && done !== 1'b1; i++) tick(1);
        req = 1'b0;
    endtask : send

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic startup(input logic b, input logic low);
        reset_n_i = 1'b0;
        boost     = b;
        batt_low  = low;
        st        = '0;
        tick(10);
        check("reset mode", mode, ST_RC_START);
        check("reset enables", en, ENABLES_RST);
        check("reset ready", ready, 1'b0);
        reset_n_i = 1'b1;
        tick(5);
        check("rf core off", en.rf_core_en, 1'b0);
        check("xtal before supply", en.xtal_en, 1'b0);
        st.supply_ok = 1'b1;
        wait_mode(ST_XTAL_WAIT, 10);
        check("xtal on", en.xtal_en, 1'b1);
        check("ready early", ready, 1'b0);
        tick(20);
        st.xtal_ok       = 1'b1;
        st.boost_settled = 1'b1;
        wait_mode(ST_STANDBY, 10);
        check("ready", ready, 1'b1);
        check("rc stopped", en.rc_osc_en, 1'b0);
        check("full regulation", en.boost_full_reg, b);
        check("radio idle", en.rf_core_en, 1'b0);
    endtask : startup

    task automatic tx_auto_ack;
        auto_ack = 1'b1;
        send(CMD_TX, 1'b0);
        wait_mode(ST_SETTLE, 5);
        check("tx en", en.tx_en, 1'b1);
        tick(20);
        st.pll_locked = 1'b1;
        wait_mode(ST_TX, STDBY_ACTIVE_CYC - 25);
        st.pll_locked  = 1'b0;
        st.packet_done = 1'b1;
        wait_mode(ST_TURN, 10);
        check("turn rx", en.rx_en, 1'b1);
        check("turn tx", en.tx_en, 1'b0);
        st.packet_done = 1'b0;
        tick(20);
        st.pll_locked = 1'b1;
        wait_mode(ST_RX, TRX_TURN_CYC - 25);
    endtask : tx_auto_ack

    task automatic rx_and_refuse;
        send(CMD_TX, 1'b0);
        tick(4);
        check("tx from rx", mode, ST_RX);
        send(CMD_STANDBY, 1'b0);
        wait_mode(ST_STANDBY, 10);
        send(CMD_RX, 1'b0);
        wait_mode(ST_RX, STDBY_ACTIVE_CYC);
        check("rx en", en.rx_en, 1'b1);
        send(CMD_TURN, 1'b0);
        wait_mode(ST_TX, TRX_TURN_CYC);
    endtask : rx_and_refuse

    task automatic tx_no_ack;
        auto_ack       = 1'b0;
        st.packet_done = 1'b1;
        wait_mode(ST_STANDBY, 20);
        st.packet_done = 1'b0;
    endtask : tx_no_ack

    task automatic sleep_wake(input logic b);
        send(CMD_STANDBY, 1'b1);
        wait_mode(ST_SLEEP, 20);
        check("xtal stopped", en.xtal_en, 1'b0);
        if (b) begin
            check("slow rc", en.lf_rc_osc_en, 1'b1);
            check("on off loop", en.boost_bang_bang, 1'b1);
        end else begin
            check("clocks off", en.clocks_en, 1'b0);
        end
        st.xtal_ok    = 1'b0;
        st.pll_locked = 1'b0;
        // Ready stays high while asleep; bypass is set anyway
        bypass = 1'b1;
        send(CMD_STANDBY, 1'b0);
        bypass = 1'b0;
        wait_mode(ST_WAKE, 10);
        tick(100);
        st.xtal_ok = 1'b1;
        if (b) wait_mode(ST_STANDBY, DEEP_WAKE_CYC - 110);
        else wait_mode(ST_STANDBY, PD_STDBY_CYC - 110);
    endtask : sleep_wake

    task automatic batt_protect;
        cmd_e cl[5];
        cl = '{CMD_STANDBY, CMD_TX, CMD_RX, CMD_TURN, CMD_BATT_PROT};
        wait_mode(ST_BATT_PROT, 20);
        check("protect flag", prot, 1'b1);
        check("load only", en, PROT_EN);
        bypass = 1'b1;
        foreach (cl[i]) begin
            send(cl[i], i[0]);
            tick(4);
            check("stuck protect", mode, ST_BATT_PROT);
        end
        bypass = 1'b0;
    endtask : batt_protect

    // Turn from transmit with no lock: only the timer ends it
    task automatic turn_timeout;
        int n;
        st.pll_locked = 1'b1;
        send(CMD_TX, 1'b0);
        wait_mode(ST_TX, 10);
        st.pll_locked = 1'b0;
        tick(3);
        send(CMD_TURN, 1'b0);
        wait_mode(ST_TURN, 5);
        for (n = 0; n < TRX_TURN_CYC + 10 && mode === ST_TURN; n++) tick(1);
        check("turn cycles", n, TRX_TURN_CYC);
        check("turn timeout", tmo, 1'b1);
        check("turn end", mode, ST_RX);
        check("turn rx en", en.rx_en, 1'b1);
    endtask : turn_timeout

    // ----------------------------------------------------------------
    // Sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        clk_sys_i = 1'b0;
        reset_n_i = 1'b0;
        boost     = 1'b1;
        st        = '0;
        auto_ack  = 1'b0;
        batt_low  = 1'b0;
        bypass    = 1'b0;
        req       = 1'b0;
        req_cmd   = CMD_NONE;
        req_deep  = 1'b0;
        saw_to    = 1'b0;
        errors    = 0;
        cmp_count = 0;
        startup(1'b1, 1'b0);
        tx_auto_ack();
        rx_and_refuse();
        tx_no_ack();
        sleep_wake(1'b1);
        startup(1'b1, 1'b1);
        batt_protect();
        startup(1'b0, 1'b0);
        sleep_wake(1'b0);
        // Locks came in time, so no timer may expire
        check("timeout seen", saw_to, 1'b0);
        turn_timeout();
        complete_run();
    end

    // Whole run is a few thousand cycles
    initial begin
        #(CLK_NS * 40000);
        errors++;
        complete_run();
    end
endmodule : transceiver_power_mode_sequencer_tb
